/* src/mdx_cfg.svh */
// mdx_cfg.svh: offsets, field positions, reset values and opcode patterns
`ifndef MDX_CFG_SVH
`define MDX_CFG_SVH

// register byte offsets (haddr[7:0])
`define MDX_A_CTRL   8'h00
`define MDX_A_STATUS 8'h04
`define MDX_A_ACC    8'h08
`define MDX_A_PC     8'h0c
`define MDX_A_PTR0   8'h10
`define MDX_A_PTR1   8'h14
`define MDX_A_PCHI   8'h18
`define MDX_A_DIRLO  8'h1c
`define MDX_A_DIRHI  8'h20

// status word bit positions
`define MDX_ST_C   0
`define MDX_ST_DC  1
`define MDX_ST_Z   2
`define MDX_ST_PD  3
`define MDX_ST_TO  4
`define MDX_ST_GIE 5
`define MDX_ST_SLP 6

// reset values
`define MDX_RST_ACC  8'h00
`define MDX_RST_PTR  16'h0000
`define MDX_RST_PC   15'h0000
`define MDX_RST_PCHI 7'h00
`define MDX_RST_DIR  64'hffff_ffff_ffff_ffff
`define MDX_RST_SP   4'h0
`define MDX_RST_FLAGS 7'h18

// fixed opcodes
`define MDX_OP_RESET  14'h0001
`define MDX_OP_RETURN 14'h0008
`define MDX_OP_INTERRUPT_RETURN 14'h0009
`define MDX_OP_CALL_VIA_ACCUMULATOR  14'h000a
`define MDX_OP_BRW    14'h000b
`define MDX_OP_SLEEP  14'h0063
`define MDX_OP_WATCHDOG_CLEAR_OP 14'h0064

// opcode prefixes
`define MDX_P_DIR   11'h00c
`define MDX_P_ILD   11'h002
`define MDX_P_IST   11'h003
`define MDX_P_CALL  3'h4
`define MDX_P_GOTO  3'h5
`define MDX_P_BRA   5'h19
`define MDX_P_RETURN_WITH_LITERAL 6'h34
`define MDX_P_PADD  7'h62
`define MDX_P_ILDK  7'h7e
`define MDX_P_ISTK  7'h7f
`define MDX_P_ANDL  6'h39
`define MDX_P_ADDL  6'h3e
`define MDX_P_ANDF  6'h05
`define MDX_P_WIN   6'h00

`endif

/* src/mdx_pkg.sv */
// mdx_pkg.sv: types shared by the decode and execute core
package mdx_pkg;
  typedef logic [13:0] mdx_instr_t;
  typedef logic [14:0] mdx_pc_t;
  typedef enum logic [1:0] {st_exec, st_nop2, st_xtra, st_sleep} mdx_state_t;
endpackage : mdx_pkg

/* src/mdx_add8.sv */
// mdx_add8.sv: 8-bit adder with carry and nibble carry
`timescale 1ns/1ns
`default_nettype none
module mdx_add8 (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  output logic      [7:0] sum,
  output logic            c_out,
  output logic            dc_out
);
  wire logic [4:0] lo;
  wire logic [4:0] hi;
  assign lo     = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign hi     = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
  assign sum    = {hi[3:0], lo[3:0]};
  assign c_out  = hi[4];
  assign dc_out = lo[4];
endmodule : mdx_add8
`default_nettype wire

/* src/mdx_core.sv */
// mdx_core.sv: instruction decode and execute core with AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none
`include "mdx_cfg.svh"
// How it works
// - PC-changing instructions except the reset opcode take two cycles, second cycle a no-op.
// - indirect window access with pointer MSb set adds one cycle.
// - branch_by_accumulator jumps to PC+1 plus accumulator, two cycles.
// - call_via_accumulator calls address built from accumulator, two cycles.
// - return_with_literal returns and loads literal into accumulator, two cycles.
// - sleep opcode enters standby in one cycle, sets timeout, clears powerdown.
// - pin_direction_load copies accumulator into selected direction register.
// - pointer_literal_add adds literal to chosen pointer, flags untouched.
// - pointer add literal is signed six-bit, applied to full 16-bit pointer.
// - pointer arithmetic wraps around the 16-bit range.
// - indirect_load_to_acc loads via pointer with pre/post modify, sets zero.
// - indexed load uses pointer plus signed offset, sets zero.
// - acc_store_indirect stores accumulator via pointer with pre/post modify, flags untouched.
// - indexed store writes accumulator at pointer plus offset.
// - literal_and ands literal into accumulator, zero flag only.
// - literal_add adds literal, updates carry, nibble carry and zero.
// - file_and ands accumulator with file, result by d, zero flag.
// - destination bit clear picks accumulator, set picks file register.
module mdx_core #(
  parameter int DMEM_AW  = 7,
  parameter int STACK_AW = 4
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire mdx_pkg::mdx_instr_t instr,
  input  wire logic               instr_valid,
  input  wire logic               wake,
  output logic                    instr_ready,
  output mdx_pkg::mdx_pc_t        program_counter,
  output logic [63:0]             pin_dir_flat,
  output logic                    sleeping,
  output logic                    wdt_clear,
  output logic                    soft_reset,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata
);
  import mdx_pkg::*;

  mdx_state_t      st, next_st;
  logic            run, dph_we;
  logic [7:0]      acc;
  logic [15:0]     ptr0, ptr1;
  logic [6:0]      pchi;
  logic [6:0]      flags;
  logic [7:0]      dmem [2**DMEM_AW];
  mdx_pc_t         stk [2**STACK_AW];
  logic [STACK_AW-1:0] sp;
  logic [7:0]      dph_addr;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic [7:0] lit8;
  wire logic       is_brw, is_call_via_accumulator, is_ret, is_interrupt_return, is_sleep, is_watchdog_clear_op, is_rst;
  wire logic       is_dir, is_ild, is_ist, is_call, is_goto, is_bra, is_return_with_literal;
  wire logic       is_padd, is_ildk, is_istk, is_andl, is_addl, is_andf;
  wire logic       win, dest_f, is_jump, is_pop, is_push, taken;
  assign taken     = ce && instr_ready && instr_valid;
  assign lit8      = instr[7:0];
  assign is_ret    = instr == `MDX_OP_RETURN;
  assign is_interrupt_return = instr == `MDX_OP_INTERRUPT_RETURN;
  assign is_watchdog_clear_op = instr == `MDX_OP_WATCHDOG_CLEAR_OP;
  assign is_rst    = instr == `MDX_OP_RESET;
  assign is_call   = instr[13:11] == `MDX_P_CALL;
  assign is_goto   = instr[13:11] == `MDX_P_GOTO;
  assign is_brw    = instr == `MDX_OP_BRW;
  assign is_call_via_accumulator  = instr == `MDX_OP_CALL_VIA_ACCUMULATOR;
  assign is_sleep  = instr == `MDX_OP_SLEEP;
  assign is_dir    = instr[13:3] == `MDX_P_DIR && !is_sleep && !is_watchdog_clear_op;
  assign is_ild    = instr[13:3] == `MDX_P_ILD;
  assign is_ist    = instr[13:3] == `MDX_P_IST;
  assign is_bra    = instr[13:9] == `MDX_P_BRA;
  assign is_return_with_literal  = instr[13:8] == `MDX_P_RETURN_WITH_LITERAL;
  assign is_padd   = instr[13:7] == `MDX_P_PADD;
  assign is_ildk   = instr[13:7] == `MDX_P_ILDK;
  assign is_istk   = instr[13:7] == `MDX_P_ISTK;
  assign is_andl   = instr[13:8] == `MDX_P_ANDL;
  assign is_addl   = instr[13:8] == `MDX_P_ADDL;
  assign is_andf   = instr[13:8] == `MDX_P_ANDF;
  assign win       = is_andf && (instr[6:1] == `MDX_P_WIN);
  assign dest_f    = instr[7];
  assign is_pop    = is_ret || is_interrupt_return || is_return_with_literal;
  assign is_push   = is_call || is_call_via_accumulator;
  assign is_jump   = is_pop || is_push || is_goto || is_brw || is_bra;

  ////////////////////////////////////////////////////////////////////////////
  // pointer path
  wire logic        psel, ind_acc, slow;
  wire logic [15:0] ptr_cur, kext, ptr_mod, ptr_ea, ptr_new;
  assign psel    = is_andf ? instr[0] : (is_ild || is_ist) ? instr[2] : instr[6];
  assign ptr_cur = psel ? ptr1 : ptr0;
  assign kext    = {{10{instr[5]}}, instr[5:0]};
  assign ptr_mod = instr[0] ? 16'(ptr_cur - 16'h0001) : 16'(ptr_cur + 16'h0001);
  assign ptr_ea  = (is_ildk || is_istk) ? 16'(ptr_cur + kext) :
                   (is_ild || is_ist) ? (instr[1] ? ptr_cur : ptr_mod) : ptr_cur;
  assign ptr_new = is_padd ? 16'(ptr_cur + kext) : ptr_mod;
  assign ind_acc = is_ild || is_ist || is_ildk || is_istk || win;
  // high half of pointer space is slow
  assign slow    = ind_acc && ptr_ea[15];

  ////////////////////////////////////////////////////////////////////////////
  // data path
  wire logic [DMEM_AW-1:0] ma;
  wire logic [7:0] rd, andv, sum, acc_val, mem_wd;
  wire logic       c_add, dc_add, acc_ld, z_ld, mem_we;
  assign ma      = (is_andf && !win) ? DMEM_AW'(instr[6:0]) : ptr_ea[DMEM_AW-1:0];
  assign rd      = dmem[ma];
  assign andv    = acc & (is_andl ? lit8 : rd);
  mdx_add8 u_add (
    .a      (acc),
    .b      (lit8),
    .cin    (1'b0),
    .sum    (sum),
    .c_out  (c_add),
    .dc_out (dc_add)
  );
  assign acc_val = is_return_with_literal ? lit8 : (is_andl || is_andf) ? andv : is_addl ? sum : rd;
  // result to acc when d clear
  assign acc_ld  = taken && (is_return_with_literal || is_andl || is_addl || is_ild || is_ildk ||
                             (is_andf && !dest_f));
  // zero flag on logic, literal add and load ops
  assign z_ld    = taken && (is_andl || is_addl || is_ild || is_ildk || is_andf);
  assign mem_we  = taken && (is_ist || is_istk || (is_andf && dest_f));
  assign mem_wd  = is_andf ? andv : acc;

  ////////////////////////////////////////////////////////////////////////////
  // program counter and sequencing
  wire mdx_pc_t pc_inc, next_pc, tgt_call;
  wire logic    next_run;
  assign pc_inc   = 15'(program_counter + 15'h0001);
  assign tgt_call = {pchi[6:3], instr[10:0]};
  // relative by acc; via acc; pop
  assign next_pc  = is_rst ? `MDX_RST_PC :
                    is_brw ? 15'(pc_inc + {7'h00, acc}) :
                    is_call_via_accumulator ? {pchi, acc} :
                    (is_call || is_goto) ? tgt_call :
                    is_bra ? 15'(pc_inc + {{6{instr[8]}}, instr[8:0]}) :
                    is_pop ? stk[STACK_AW'(sp - 1'b1)] : pc_inc;

  always_comb begin
    next_st = st;
    unique case (st)
      st_exec: if (taken)
        next_st = is_jump ? st_nop2 : slow ? st_xtra : is_sleep ? st_sleep : st_exec;
      st_nop2, st_xtra: next_st = st_exec;
      st_sleep: if (wake) next_st = st_exec;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic        ahb_go;
  wire logic        wr_ctrl, wr_st, wr_acc, wr_p0, wr_p1, wr_pchi;
  wire logic [31:0] rd_mux;
  assign ahb_go   = hsel && hready && htrans[1];
  assign wr_ctrl  = dph_we && dph_addr == `MDX_A_CTRL;
  assign wr_st    = dph_we && dph_addr == `MDX_A_STATUS;
  assign wr_acc   = dph_we && dph_addr == `MDX_A_ACC;
  assign wr_p0    = dph_we && dph_addr == `MDX_A_PTR0;
  assign wr_p1    = dph_we && dph_addr == `MDX_A_PTR1;
  assign wr_pchi  = dph_we && dph_addr == `MDX_A_PCHI;
  assign next_run = wr_ctrl ? hwdata[0] : run;
  assign rd_mux   = haddr[7:0] == `MDX_A_CTRL   ? {31'h0, run} :
                    haddr[7:0] == `MDX_A_STATUS ? {25'h0, flags} :
                    haddr[7:0] == `MDX_A_ACC    ? {24'h0, acc} :
                    haddr[7:0] == `MDX_A_PC     ? {17'h0, program_counter} :
                    haddr[7:0] == `MDX_A_PTR0   ? {16'h0, ptr0} :
                    haddr[7:0] == `MDX_A_PTR1   ? {16'h0, ptr1} :
                    haddr[7:0] == `MDX_A_PCHI   ? {25'h0, pchi} :
                    haddr[7:0] == `MDX_A_DIRLO  ? pin_dir_flat[31:0] :
                    haddr[7:0] == `MDX_A_DIRHI  ? pin_dir_flat[63:32] : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dph_we    <= 1'b0;
      dph_addr  <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dph_we    <= ahb_go && hwrite;
      dph_addr  <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ahb_go && !hwrite)
        hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st              <= st_exec;
      run             <= 1'b0;
      instr_ready     <= 1'b0;
      program_counter <= `MDX_RST_PC;
      sp              <= `MDX_RST_SP;
      sleeping        <= 1'b0;
      wdt_clear       <= 1'b0;
      soft_reset      <= 1'b0;
    end else begin
      run <= next_run;
      if (ce) begin
        st          <= next_st;
        instr_ready <= next_st == st_exec && next_run;
        sleeping    <= next_st == st_sleep;
        wdt_clear   <= taken && is_watchdog_clear_op;
        soft_reset  <= taken && is_rst;
        if (taken) begin
          program_counter <= next_pc;
          if (is_push)
            sp <= STACK_AW'(sp + 1'b1);
          else if (is_pop)
            sp <= STACK_AW'(sp - 1'b1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (taken && is_push)
      stk[sp] <= pc_inc;
    if (mem_we)
      dmem[ma] <= mem_wd;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc          <= `MDX_RST_ACC;
      ptr0         <= `MDX_RST_PTR;
      ptr1         <= `MDX_RST_PTR;
      pchi         <= `MDX_RST_PCHI;
      pin_dir_flat <= `MDX_RST_DIR;
    end else begin
      if (wr_acc)
        acc <= hwdata[7:0];
      else if (acc_ld)
        acc <= acc_val;
      if (wr_p0)
        ptr0 <= hwdata[15:0];
      else if (taken && (is_padd || is_ild || is_ist) && !psel)
        ptr0 <= ptr_new;
      if (wr_p1)
        ptr1 <= hwdata[15:0];
      else if (taken && (is_padd || is_ild || is_ist) && psel)
        ptr1 <= ptr_new;
      if (wr_pchi)
        pchi <= hwdata[6:0];
      if (taken && is_dir)
        pin_dir_flat[instr[2:0]*8 +: 8] <= acc;
    end
  end

  // flags: tie-breaks give the bus write priority
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= `MDX_RST_FLAGS;
    end else begin
      flags[`MDX_ST_SLP] <= ce ? next_st == st_sleep : flags[`MDX_ST_SLP];
      if (taken && (is_sleep || is_watchdog_clear_op)) begin
        flags[`MDX_ST_TO] <= 1'b1;
        flags[`MDX_ST_PD] <= is_watchdog_clear_op;
      end
      if (wr_st) begin
        flags[`MDX_ST_C]   <= hwdata[`MDX_ST_C];
        flags[`MDX_ST_DC]  <= hwdata[`MDX_ST_DC];
        flags[`MDX_ST_Z]   <= hwdata[`MDX_ST_Z];
        flags[`MDX_ST_GIE] <= hwdata[`MDX_ST_GIE];
      end else begin
        if (z_ld)
          flags[`MDX_ST_Z] <= acc_val == 8'h00;
        if (taken && is_addl) begin
          flags[`MDX_ST_C]  <= c_add;
          flags[`MDX_ST_DC] <= dc_add;
        end
        if (taken && is_interrupt_return)
          flags[`MDX_ST_GIE] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  two_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
    taken && is_jump |=> !instr_ready ##1 (st == st_exec))
    else $error("jump did not insert one dead cycle");
  extra_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
    taken && slow && !is_jump |=> st == st_xtra && !instr_ready) else $error("no extra cycle");
  brw_target_a: assert property (@(posedge clk) disable iff (!rst_n)
    taken && is_brw |=> program_counter == 15'($past(program_counter) + 1 + $past(acc)))
    else $error("branch by accumulator wrong target");
  call_via_accumulator_target_a: assert property (@(posedge clk) disable iff (!rst_n)
    taken && is_call_via_accumulator |=> program_counter == {$past(pchi), $past(acc)})
    else $error("call via accumulator wrong target");
  return_with_literal_acc_a: assert property (@(posedge clk) disable iff (!rst_n)
    taken && is_return_with_literal && !wr_acc |=> acc == $past(lit8)) else $error("literal not loaded");
  sleep_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    taken && is_sleep |=> flags[`MDX_ST_TO] && !flags[`MDX_ST_PD] && sleeping)
    else $error("sleep flags or state wrong");
  ptr_add_a: assert property (@(posedge clk) disable iff (!rst_n)
    taken && is_padd && !instr[6] && !wr_p0 && !wr_st
    |=> ptr0 == 16'($past(ptr0) + $past(kext)) && $stable(flags))
    else $error("pointer add wrong or flags moved");
  addl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    taken && is_addl && !wr_st && !wr_acc |=> flags[`MDX_ST_Z] == (acc == 8'h00))
    else $error("literal add zero flag mismatch");
  andf_dest_a: assert property (@(posedge clk) disable iff (!rst_n)
    taken && is_andf && dest_f && !wr_acc |=> $stable(acc)) else $error("acc touched");
endmodule : mdx_core
`default_nettype wire

/* bench/mdx_prog_mem.sv */
// program memory model that feeds opcodes to the core
`timescale 1ns/1ns
`default_nettype none
module mdx_prog_mem (
  input  wire mdx_pkg::mdx_pc_t    program_counter,
  output var  mdx_pkg::mdx_instr_t instr,
  output var  logic                instr_valid
);
  import mdx_pkg::*;
  mdx_instr_t mem    [0:32767];
  logic       loaded [0:32767];
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 14'h0000;
      loaded[i] = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  // empty words show a pattern that moves with the address
  assign instr_valid = loaded[program_counter];
  assign instr = instr_valid ? mem[program_counter] : ~program_counter[13:0];
endmodule : mdx_prog_mem
`default_nettype wire

/* bench/mcu_instr_decode_exec_test.sv */
// self-checking bench for the instruction decode and execute core
`timescale 1ns/1ns
`default_nettype none
`include "mdx_cfg.svh"
module mcu_instr_decode_exec_test;
  import mdx_pkg::*;
  typedef struct packed {
    logic [13:0] op;
    logic [7:0]  acc;
    logic [2:0]  st;
    logic [15:0] ptr;
    logic [7:0]  eacc;
    logic [2:0]  est;
    logic [15:0] eptr;
    logic [2:0]  rel;
    logic        dead;
  } mdx_row_t;
  logic        clk, rst_n, instr_ready, instr_valid, sleeping, wdt_clear, soft_reset;
  logic        ce = 1'b1, wake = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [63:0] pin_dir_flat;
  mdx_instr_t  instr;
  mdx_pc_t     program_counter, pc0;
  int          errors = 0, check_count = 0, takes = 0, wdts = 0, rsts = 0, dead, k, n, m;
  int          dir_sel [4] = '{0, 5, 6, 7};
  // st and est hold {zero, nibble carry, carry}
  mdx_row_t rows [26] = '{
    '{14'h390f, 8'hf0, 3'h3, 16'h0000, 8'h00, 3'h7, 16'h0000, 3'd1, 1'b0},
    '{14'h3e01, 8'hff, 3'h0, 16'h0000, 8'h00, 3'h7, 16'h0000, 3'd1, 1'b0},
    '{14'h3e08, 8'h08, 3'h7, 16'h0000, 8'h10, 3'h2, 16'h0000, 3'd1, 1'b0},
    '{14'h313f, 8'h00, 3'h5, 16'h0000, 8'h00, 3'h5, 16'hffff, 3'd1, 1'b0},
    '{14'h311f, 8'h00, 3'h5, 16'h00ff, 8'h00, 3'h5, 16'h011e, 3'd1, 1'b0},
    '{14'h3101, 8'h00, 3'h0, 16'hffff, 8'h00, 3'h0, 16'h0000, 3'd1, 1'b0},
    '{14'h3141, 8'h00, 3'h2, 16'h1234, 8'h00, 3'h2, 16'h1234, 3'd1, 1'b0},
    '{14'h001a, 8'h5a, 3'h4, 16'h0020, 8'h5a, 3'h4, 16'h0021, 3'd1, 1'b0},
    '{14'h0011, 8'h00, 3'h4, 16'h0021, 8'h5a, 3'h0, 16'h0020, 3'd1, 1'b0},
    '{14'h3f82, 8'h00, 3'h3, 16'h0030, 8'h00, 3'h3, 16'h0030, 3'd1, 1'b0},
    '{14'h3f3e, 8'h77, 3'h3, 16'h0034, 8'h00, 3'h7, 16'h0034, 3'd1, 1'b0},
    '{14'h0520, 8'h0f, 3'h7, 16'h0000, 8'h0a, 3'h3, 16'h0000, 3'd1, 1'b0},
    '{14'h05a0, 8'hf0, 3'h3, 16'h0000, 8'hf0, 3'h3, 16'h0000, 3'd1, 1'b0},
    '{14'h3f00, 8'h00, 3'h0, 16'h0020, 8'h50, 3'h0, 16'h0020, 3'd1, 1'b0},
    '{14'h3f00, 8'h00, 3'h0, 16'h8020, 8'h50, 3'h0, 16'h8020, 3'd1, 1'b1},
    '{14'h0500, 8'hff, 3'h0, 16'h8020, 8'h50, 3'h0, 16'h8020, 3'd1, 1'b1},
    '{14'h0010, 8'h00, 3'h4, 16'h001f, 8'h50, 3'h0, 16'h0020, 3'd1, 1'b0},
    '{14'h0013, 8'h00, 3'h0, 16'h0020, 8'h50, 3'h0, 16'h001f, 3'd1, 1'b0},
    '{14'h0018, 8'h33, 3'h0, 16'h001f, 8'h33, 3'h0, 16'h0020, 3'd1, 1'b0},
    '{14'h0012, 8'h00, 3'h4, 16'h0020, 8'h33, 3'h0, 16'h0021, 3'd1, 1'b0},
    '{14'h0019, 8'h44, 3'h0, 16'h0021, 8'h44, 3'h0, 16'h0020, 3'd1, 1'b0},
    '{14'h001b, 8'h66, 3'h0, 16'h0021, 8'h66, 3'h0, 16'h0020, 3'd1, 1'b0},
    '{14'h3f01, 8'h00, 3'h0, 16'h0020, 8'h66, 3'h0, 16'h0020, 3'd1, 1'b0},
    '{14'h3f3f, 8'h00, 3'h0, 16'h0021, 8'h44, 3'h0, 16'h0021, 3'd1, 1'b0},
    '{14'h000b, 8'h03, 3'h0, 16'h0000, 8'h03, 3'h0, 16'h0000, 3'd4, 1'b1},
    '{14'h0000, 8'h12, 3'h5, 16'h0000, 8'h12, 3'h5, 16'h0000, 3'd1, 1'b0}
  };
  ////////////////////////////////////////////////////////////////////////////////////////
  mdx_core mdx_core_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .instr(instr), .instr_valid(instr_valid),
    .wake(wake), .instr_ready(instr_ready), .program_counter(program_counter),
    .pin_dir_flat(pin_dir_flat), .sleeping(sleeping), .wdt_clear(wdt_clear),
    .soft_reset(soft_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
  );
  mdx_prog_mem mdx_prog_mem_i (
    .program_counter(program_counter),
    .instr(instr),
    .instr_valid(instr_valid)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ce && instr_ready === 1'b1 && instr_valid === 1'b1) takes++;
    if (wdt_clear === 1'b1) wdts++;
    if (soft_reset === 1'b1) rsts++;
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic hang();
    errors++;
    $display("MISMATCH %0t: wait ran out", $time);
    summarize();
  endtask : hang
  task automatic ready_wait();
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (hreadyout !== 1'b1) hang();
  endtask : ready_wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    ready_wait();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    ready_wait();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(v & mask, exp);
  endtask : rdchk
  // loads one opcode at the current address, waits for it, counts dead cycles
  task automatic step(input mdx_instr_t op);
    n = takes;
    @(negedge clk);
    pc0 = program_counter;
    mdx_prog_mem_i.mem[pc0] = op;
    @(posedge clk);
    mdx_prog_mem_i.loaded[pc0] <= 1'b1;
    for (k = 0; k < 50 && takes == n; k++) @(negedge clk);
    if (takes == n) hang();
    mdx_prog_mem_i.loaded[pc0] = 1'b0;
    dead = 0;
    repeat (3) begin
      if (instr_ready !== 1'b1) dead++;
      @(negedge clk);
    end
  endtask : step
  task automatic run_pc(input mdx_instr_t op, input mdx_pc_t pc_exp);
    step(op);
    check({17'h0, program_counter}, {17'h0, pc_exp});
    check(32'(dead), 32'd1);
  endtask : run_pc
  initial begin
    #800000;
    hang();
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check({31'h0, instr_ready}, 32'h0);
    check({17'h0, program_counter}, 32'h0);
    check(pin_dir_flat[63:32] & pin_dir_flat[31:0], 32'hffffffff);
    check({29'h0, sleeping, hreadyout, hresp}, 32'h2);
    rdchk(`MDX_A_STATUS, 32'h7f, 32'h18);
    rdchk(8'h3c, 32'hffffffff, 32'h0);
    wr(`MDX_A_PC, 32'h55);
    rdchk(`MDX_A_PC, 32'hffffffff, 32'h0);
    wr(`MDX_A_CTRL, 32'h1);
    foreach (rows[i]) begin
      wr(`MDX_A_ACC, {24'h0, rows[i].acc});
      wr(`MDX_A_STATUS, {29'h0, rows[i].st});
      wr(`MDX_A_PTR0, {16'h0, rows[i].ptr});
      step(rows[i].op);
      check(32'(dead), {31'h0, rows[i].dead});
      check({17'h0, program_counter}, {17'h0, pc0 + 15'(rows[i].rel)});
      rdchk(`MDX_A_ACC, 32'hff, {24'h0, rows[i].eacc});
      rdchk(`MDX_A_STATUS, 32'h7, {29'h0, rows[i].est});
      rdchk(`MDX_A_PTR0, 32'hffff, {16'h0, rows[i].eptr});
    end
    @(posedge clk);
    ce <= 1'b0;
    pc0 = program_counter;
    mdx_prog_mem_i.mem[pc0] = 14'h3e01;
    mdx_prog_mem_i.loaded[pc0] <= 1'b1;
    repeat (4) @(negedge clk);
    check({17'h0, program_counter}, {17'h0, pc0});
    @(posedge clk);
    ce <= 1'b1;
    mdx_prog_mem_i.loaded[pc0] <= 1'b0;
    rdchk(`MDX_A_ACC, 32'hff, 32'h12);
    run_pc(14'h2900, 15'h0100);
    wr(`MDX_A_ACC, 32'h40);
    run_pc(14'h000a, 15'h0040);
    run_pc(14'h3477, 15'h0101);
    rdchk(`MDX_A_ACC, 32'hff, 32'h77);
    run_pc(14'h2050, 15'h0050);
    run_pc(14'h0009, 15'h0102);
    rdchk(`MDX_A_STATUS, 32'h20, 32'h20);
    run_pc(14'h2060, 15'h0060);
    run_pc(14'h0008, 15'h0103);
    run_pc(14'h33fe, 15'h0102);
    foreach (dir_sel[j]) begin
      wr(`MDX_A_ACC, {24'h0, 8'h3c ^ 8'(dir_sel[j])});
      step(14'h0060 | 14'(dir_sel[j]));
      check({24'h0, pin_dir_flat[8*dir_sel[j] +: 8]}, {24'h0, 8'h3c ^ 8'(dir_sel[j])});
    end
    check({24'h0, pin_dir_flat[15:8]}, 32'hff);
    step(14'h0063);
    check({31'h0, sleeping}, 32'h1);
    check(32'(dead), 32'd3);
    rdchk(`MDX_A_STATUS, 32'h18, 32'h10);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (3) @(negedge clk);
    check({30'h0, sleeping, instr_ready}, 32'h1);
    m = wdts;
    step(14'h0064);
    check(32'(wdts - m), 32'd1);
    rdchk(`MDX_A_STATUS, 32'h18, 32'h18);
    check(pin_dir_flat[39:8], 32'hffffffff);
    m = rsts;
    step(14'h0001);
    check(32'(rsts - m), 32'd1);
    check({17'h0, program_counter}, 32'h0);
    wr(`MDX_A_ACC, 32'haa);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    check({pin_dir_flat[63:40], 7'h0, instr_ready}, 32'hffffff00);
    @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`MDX_A_ACC, 32'hff, 32'h0);
    summarize();
  end
endmodule : mcu_instr_decode_exec_test
`default_nettype wire
